// >>> spwi_asserts.sv
`timescale 1ns/10ps
// pin-level checks on the wiper interface, system clock domain only
module spwi_asserts #(
    parameter int unsigned NV_WRITE_CYCLES = spwi_pkg::NV_WRITE_CYCLES,
    parameter logic [9:0] DR_INIT = spwi_pkg::DR_RST
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic CS_N_I,
    input wire logic HOLD_N_I,
    input wire logic WP_N_I,
    input wire logic SO_O,
    input wire logic SO_OE_O,
    input wire logic [9:0] WIPER_POS_O,
    input wire logic [1023:0] TAP_SEL_O,
    input wire logic NV_BUSY_O,
    input wire logic STANDBY_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] busy_cnt_ff; // length of the current busy run
    logic [31:0] nxt_busy_cnt; // next run length
    // counter instead of a long repetition, which would be slow to unroll
    always_comb begin
        nxt_busy_cnt = (RESETN_I && NV_BUSY_O) ? busy_cnt_ff + 32'h1 : 32'h0;
    end
    // register only
    always_ff @(posedge CLK_I) begin
        busy_cnt_ff <= nxt_busy_cnt;
    end
    property p_recall; $rose(RESETN_I) |=> WIPER_POS_O == DR_INIT; endproperty
    a_recall: assert property (p_recall) else $error("wiper not loaded at power-up");
    property p_tap; $past(RESETN_I) |-> TAP_SEL_O == (1024'h1 << $past(WIPER_POS_O)); endproperty
    a_tap: assert property (p_tap) else $error("tap select not one-hot of wiper");
    property p_float; CS_N_I |-> !SO_OE_O && !SO_O; endproperty
    a_float: assert property (p_float) else $error("serial output driven while deselected");
    property p_pause; !HOLD_N_I |-> !SO_OE_O; endproperty
    a_pause: assert property (p_pause) else $error("serial output driven during pause");
    // the timer holds busy for exactly NV_WRITE_CYCLES cycles, one more than its loaded count
    property p_busy_max; busy_cnt_ff <= NV_WRITE_CYCLES; endproperty
    a_busy_max: assert property (p_busy_max) else $error("write cycle too long");
    property p_busy_len; $fell(NV_BUSY_O) |-> busy_cnt_ff == NV_WRITE_CYCLES; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy flag length wrong");
    property p_active; !CS_N_I [*4] |-> !STANDBY_O; endproperty
    a_active: assert property (p_active) else $error("standby while selected");
    property p_nv_awake; NV_BUSY_O && $past(NV_BUSY_O) |-> !STANDBY_O; endproperty
    a_nv_awake: assert property (p_nv_awake) else $error("standby during write cycle");
    property p_protect; !WP_N_I [*6] |-> !$rose(NV_BUSY_O); endproperty
    a_protect: assert property (p_protect) else $error("write started while protected");
endmodule

bind spwi_top spwi_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES), .DR_INIT(DR_INIT)) u_chk (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .CS_N_I(CS_N_I), .HOLD_N_I(HOLD_N_I),
    .WP_N_I(WP_N_I), .SO_O(SO_O), .SO_OE_O(SO_OE_O), .WIPER_POS_O(WIPER_POS_O),
    .TAP_SEL_O(TAP_SEL_O), .NV_BUSY_O(NV_BUSY_O), .STANDBY_O(STANDBY_O));

// >>> spwi_host.sv
`timescale 1ns/10ps
// serial host: 12 ns clock that only runs inside frames, idle low
module spwi_host (
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o,
    output logic hold_n_o,
    input wire logic so_i,
    input wire logic so_oe_i
);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b0;
        si_o = 1'b0;
        hold_n_o = 1'b1;
        // a clean rising select resets the receiver whatever its start-up state
        #1 cs_n_o = 1'b1;
    end
    // nb bits msb first; pause before bit pz; rd holds bits 17..32, x when floating
    task automatic frame(input logic [31:0] bits, input int nb, input int pz,
                         output logic [15:0] rd);
        rd = 16'h0000;
        cs_n_o = 1'b0;
        #250; // lets the deselected snapshot settle before read data
        for (int i = 0; i < nb; i++) begin
            if (i == pz) begin
                // not in the falling edge's time step, which still drives a bit
                #3 hold_n_o = 1'b0;
                repeat (3) begin
                    si_o = ~si_o;
                    #6 sck_o = 1'b1;
                    #6 sck_o = 1'b0;
                end
                #6 hold_n_o = 1'b1;
                #6;
            end
            si_o = bits[31-i];
            #6 sck_o = 1'b1;
            if (i >= 16) begin
                rd = {rd[14:0], so_oe_i ? so_i : 1'bx};
            end
            #6 sck_o = 1'b0;
        end
        #200 cs_n_o = 1'b1;
        si_o = ~si_o; // a released line does not keep its last level
        #200;
    endtask
endmodule

// >>> spwi_nv_store.sv
`timescale 1ns/10ps
module spwi_nv_store #(
    parameter int unsigned WIDTH = spwi_pkg::WIPER_W,
    parameter int unsigned NUM = spwi_pkg::NUM_DR,
    parameter int unsigned WRITE_CYCLES = spwi_pkg::NV_WRITE_CYCLES,
    parameter logic [WIDTH-1:0] INIT = spwi_pkg::DR_RST
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic start_i,
    input wire logic [$clog2(NUM)-1:0] idx_i,
    input wire logic [WIDTH-1:0] data_i,
    output logic busy_o,
    output logic [NUM*WIDTH-1:0] bank_o
);

    localparam int unsigned CNT_W = $clog2(WRITE_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(WRITE_CYCLES - 1);

    logic [WIDTH-1:0] dr_ff [NUM];         // stored words
    logic [WIDTH-1:0] nxt_dr [NUM];
    logic busy_ff;                         // write cycle running
    logic nxt_busy;
    logic [CNT_W-1:0] cnt_ff;              // cycles left in write
    logic [CNT_W-1:0] nxt_cnt;
    logic [$clog2(NUM)-1:0] idx_ff;        // target register
    logic [$clog2(NUM)-1:0] nxt_idx;
    logic [WIDTH-1:0] data_ff;             // word being written
    logic [WIDTH-1:0] nxt_data;

    ////////////////////////////////////////////////////////////////////////////////
    // write timer; the word lands only at the end, like a real cell
    always_comb begin
        nxt_dr = dr_ff;
        nxt_busy = busy_ff;
        nxt_cnt = cnt_ff;
        nxt_idx = idx_ff;
        nxt_data = data_ff;
        if (busy_ff) begin
            if (cnt_ff == '0) begin
                nxt_dr[idx_ff] = data_ff;
                nxt_busy = 1'b0;
            end else begin
                nxt_cnt = cnt_ff - 1'b1;
            end
        end else if (start_i) begin
            // a request while busy is dropped by the caller gating
            nxt_busy = 1'b1;
            nxt_cnt = CNT_LOAD;
            nxt_idx = idx_i;
            nxt_data = data_i;
        end
    end

    // register the bank and timer
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < NUM; i++) begin
                dr_ff[i] <= INIT;
            end
            busy_ff <= 1'b0;
            cnt_ff <= '0;
            idx_ff <= '0;
            data_ff <= '0;
        end else begin
            dr_ff <= nxt_dr;
            busy_ff <= nxt_busy;
            cnt_ff <= nxt_cnt;
            idx_ff <= nxt_idx;
            data_ff <= nxt_data;
        end
    end

    // flatten for the parent
    always_comb begin
        for (int i = 0; i < NUM; i++) begin
            bank_o[i*WIDTH +: WIDTH] = dr_ff[i];
        end
    end

    assign busy_o = busy_ff;

endmodule

// >>> spwi_pkg.sv
// Notes on behaviour
// - read data driven on falling serial clock
// - serial input sampled on rising serial clock
// - pause low freezes sequence, keeps progress
// - address bit must match address pin
// - deselected device floats serial output
// - standby when deselected unless nonvolatile write
// - select low makes device active
// - ignore traffic until first select fall (only command execution waits for it; reads are still answered)
// - write protect low blocks data register writes
// - power-up copies register zero into wiper
// - ten-bit wiper picks one of 1024 taps
// - four readable, writable nonvolatile data registers
// - first byte: type, address bit, direction
// - second byte: opcode and register selector
// - write busy flag readable while writing
// - nonvolatile write finishes within 10 ms
package spwi_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // widths and counts
    localparam int unsigned WIPER_W = 10;     // wiper and data register width
    localparam int unsigned TAP_COUNT = 1024; // resistor taps
    localparam int unsigned NUM_DR = 4;       // nonvolatile data registers
    localparam int unsigned SEL_W = 2;        // register selector width
    localparam int unsigned OP_W = 3;         // opcode width
    localparam int unsigned TYPE_W = 4;       // device type field width

    ////////////////////////////////////////////////////////////////////////////////
    // identification byte layout
    localparam int unsigned ID_TYPE_LO = 4;   // device_type_field in bits 7:4
    localparam int unsigned ID_ADDR_BIT = 1;  // device address bit
    localparam int unsigned ID_RW_BIT = 0;    // 1 = read

    // instruction byte layout
    localparam int unsigned INS_OP_LO = 5;    // opcode in bits 7:5
    localparam int unsigned INS_SEL_LO = 2;   // register_select_hi/lo in bits 3:2

    ////////////////////////////////////////////////////////////////////////////////
    // rising edge counts at which a byte is complete
    localparam logic [4:0] BIT_ID_LAST = 5'h07;
    localparam logic [4:0] BIT_INS_LAST = 5'h0f;
    localparam logic [4:0] BIT_DLO_LAST = 5'h17;
    localparam logic [4:0] BIT_DHI_LAST = 5'h1f;

    ////////////////////////////////////////////////////////////////////////////////
    // opcodes
    localparam logic [2:0] OP_RD_STATUS = 3'h1;
    localparam logic [2:0] OP_XFR_WCR_TO_DR = 3'h2;
    localparam logic [2:0] OP_XFR_DR_TO_WCR = 3'h3;
    localparam logic [2:0] OP_RD_WCR = 3'h4;
    localparam logic [2:0] OP_WR_WCR = 3'h5;
    localparam logic [2:0] OP_RD_DR = 3'h6;
    localparam logic [2:0] OP_WR_DR = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [9:0] WIPER_RST = 10'h000;
    localparam logic [9:0] DR_RST = 10'h000;

    ////////////////////////////////////////////////////////////////////////////////
    // frozen snapshot layout handed to the serial clock domain
    localparam int unsigned SNAP_WCR_LO = 40;
    localparam int unsigned SNAP_WIP = 50;
    localparam int unsigned SNAP_A0 = 51;
    localparam int unsigned SNAP_W = 52;

    ////////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int unsigned CLK_FREQ_HZ = 20000000;
    localparam int unsigned NV_WRITE_TIME_MS = 10;
    // longest time, rounded down to whole cycles
    localparam int unsigned NV_WRITE_CYCLES = NV_WRITE_TIME_MS * (CLK_FREQ_HZ / 1000);

    ////////////////////////////////////////////////////////////////////////////////
    // serial receiver states
    typedef enum logic [2:0] {
        LS_ID,
        LS_INS,
        LS_DATA,
        LS_DONE,
        LS_IGNORE
    } spwi_link_e;

    // pick one data register out of the flattened bank
    function automatic logic [9:0] pick_dr(input logic [39:0] flat, input logic [1:0] sel);
        pick_dr = flat[sel * WIPER_W +: WIPER_W];
    endfunction

endpackage

// >>> spwi_sync.sv
`timescale 1ns/10ps
module spwi_sync #(
    parameter int unsigned W = 1
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);

    logic [W-1:0] meta_ff;     // first stage, read only by second stage
    logic [W-1:0] sync_ff;     // second stage
    logic [W-1:0] nxt_meta;
    logic [W-1:0] nxt_sync;

    // next values of the two stages
    always_comb begin
        nxt_meta = d_i;
        nxt_sync = meta_ff;
    end

    // register both stages
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
        end
    end

    assign q_o = sync_ff;

endmodule

// >>> spwi_top.sv
`timescale 1ns/10ps
module spwi_top #(
    parameter logic [3:0] DEV_TYPE = 4'h9,          // arbitrary value
    parameter int unsigned NV_WRITE_CYCLES = spwi_pkg::NV_WRITE_CYCLES,
    parameter logic [9:0] DR_INIT = spwi_pkg::DR_RST
) (
    input wire logic CLK_I,
    input wire logic RESETN_I,
    input wire logic SCK_I,
    input wire logic CS_N_I,
    input wire logic SI_I,
    input wire logic HOLD_N_I,
    input wire logic WP_N_I,
    input wire logic DEV_ADDR_PIN_I,
    output logic SO_O,
    output logic SO_OE_O,
    output logic [9:0] WIPER_POS_O,
    output logic [1023:0] TAP_SEL_O,
    output logic NV_BUSY_O,
    output logic STANDBY_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // serial clock domain declarations
    spwi_pkg::spwi_link_e state_ff;   // receiver state
    spwi_pkg::spwi_link_e nxt_state;
    logic [4:0] cnt_ff;               // rising edges seen in frame
    logic [4:0] nxt_cnt;
    logic [7:0] sh_ff;                // input shifter
    logic [7:0] nxt_sh;
    logic rd_active_ff;               // read data phase owns the output
    logic nxt_rd_active;
    logic done_ff;                    // complete command waiting
    logic nxt_done;
    logic so_ff;                      // output bit, falling edge
    logic nxt_so;
    // command fields: no reset, they must outlive the select rise
    logic [2:0] op_ff;
    logic [2:0] nxt_op;
    logic [1:0] sel_ff;
    logic [1:0] nxt_sel;
    logic rw_ff;
    logic nxt_rw;
    logic [7:0] dlo_ff;
    logic [7:0] nxt_dlo;
    logic [1:0] dhi_ff;
    logic [1:0] nxt_dhi;
    logic [7:0] sh_in;                // shifter with this edge's bit
    logic [9:0] rd_word;              // word chosen for read
    logic [15:0] out16;               // two read bytes in wire order

    ////////////////////////////////////////////////////////////////////////////////
    // system clock domain declarations
    logic [3:0] sync_q;               // synced cs, wp, addr, done
    logic cs_s;
    logic wp_s;
    logic a0_s;
    logic done_s;
    logic cs_prev_ff;                 // last synced select
    logic nxt_cs_prev;
    logic armed_ff;                   // a select fall has been seen
    logic nxt_armed;
    logic done_prev_ff;               // for done edge detect
    logic nxt_done_prev;
    logic recall_ff;                  // power-up recall pending
    logic nxt_recall;
    logic [9:0] wcr_ff;               // wiper_position_reg
    logic [9:0] nxt_wcr;
    logic [1023:0] tap_ff;            // one-hot tap switches
    logic [1023:0] nxt_tap;
    logic standby_ff;
    logic nxt_standby;
    logic [spwi_pkg::SNAP_W-1:0] snap_ff;   // frozen while selected
    logic [spwi_pkg::SNAP_W-1:0] nxt_snap;
    logic exec;                       // one-cycle command strobe
    logic nv_start;
    logic [9:0] nv_data;
    logic nv_busy;
    logic [39:0] bank;                // data registers, flattened
    logic [9:0] cmd_data;

    ////////////////////////////////////////////////////////////////////////////////
    // receiver next state, one step per rising serial clock
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_rd_active = rd_active_ff;
        nxt_done = done_ff;
        nxt_op = op_ff;
        nxt_sel = sel_ff;
        nxt_rw = rw_ff;
        nxt_dlo = dlo_ff;
        nxt_dhi = dhi_ff;
        sh_in = {sh_ff[6:0], SI_I};
        // pause changes only while the clock is low, so it is steady here
        if (HOLD_N_I) begin
            case (state_ff)
                spwi_pkg::LS_ID: begin
                    nxt_sh = sh_in;
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == spwi_pkg::BIT_ID_LAST) begin
                        // address pin value frozen in the snapshot
                        if (sh_in[7:spwi_pkg::ID_TYPE_LO] == DEV_TYPE &&
                            sh_in[spwi_pkg::ID_ADDR_BIT] == snap_ff[spwi_pkg::SNAP_A0]) begin
                            nxt_rw = sh_in[spwi_pkg::ID_RW_BIT];
                            nxt_state = spwi_pkg::LS_INS;
                        end else begin
                            nxt_state = spwi_pkg::LS_IGNORE;
                        end
                    end
                end
                spwi_pkg::LS_INS: begin
                    nxt_sh = sh_in;
                    nxt_cnt = cnt_ff + 5'h01;
                    if (cnt_ff == spwi_pkg::BIT_INS_LAST) begin
                        nxt_op = sh_in[7:spwi_pkg::INS_OP_LO];
                        nxt_sel = sh_in[spwi_pkg::INS_SEL_LO +: spwi_pkg::SEL_W];
                        case (sh_in[7:spwi_pkg::INS_OP_LO])
                            spwi_pkg::OP_XFR_DR_TO_WCR,
                            spwi_pkg::OP_XFR_WCR_TO_DR: begin
                                // two-byte command ends here
                                nxt_done = 1'b1;
                                nxt_state = spwi_pkg::LS_DONE;
                            end
                            spwi_pkg::OP_RD_WCR,
                            spwi_pkg::OP_RD_DR,
                            spwi_pkg::OP_RD_STATUS: begin
                                nxt_rd_active = 1'b1;
                                nxt_state = spwi_pkg::LS_DATA;
                            end
                            default: begin
                                nxt_state = spwi_pkg::LS_DATA;
                            end
                        endcase
                    end
                end
                spwi_pkg::LS_DATA: begin
                    nxt_sh = sh_in;
                    if (cnt_ff == spwi_pkg::BIT_DLO_LAST) begin
                        nxt_dlo = sh_in;
                    end
                    if (cnt_ff == spwi_pkg::BIT_DHI_LAST) begin
                        // count held at the end so the last bit stays put
                        nxt_dhi = sh_in[1:0];
                        nxt_done = ~rd_active_ff;
                        nxt_state = spwi_pkg::LS_DONE;
                    end else begin
                        nxt_cnt = cnt_ff + 5'h01;
                    end
                end
                default: begin
                    // done or ignoring: wait for the select to rise
                end
            endcase
        end
    end

    // select high is the receiver's reset: aborts and floats the output
    always_ff @(posedge SCK_I or posedge CS_N_I) begin
        if (CS_N_I) begin
            state_ff <= spwi_pkg::LS_ID;
            cnt_ff <= 5'h00;
            sh_ff <= 8'h00;
            rd_active_ff <= 1'b0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            rd_active_ff <= nxt_rd_active;
            done_ff <= nxt_done;
        end
    end

    // command fields, held across the select rise for the other domain
    always_ff @(posedge SCK_I) begin
        op_ff <= nxt_op;
        sel_ff <= nxt_sel;
        rw_ff <= nxt_rw;
        dlo_ff <= nxt_dlo;
        dhi_ff <= nxt_dhi;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read word from the frozen snapshot, then the output bit
    always_comb begin
        case (op_ff)
            spwi_pkg::OP_RD_WCR: rd_word = snap_ff[spwi_pkg::SNAP_WCR_LO +: spwi_pkg::WIPER_W];
            spwi_pkg::OP_RD_DR: rd_word = spwi_pkg::pick_dr(snap_ff[39:0], sel_ff);
            spwi_pkg::OP_RD_STATUS: rd_word = {9'h000, snap_ff[spwi_pkg::SNAP_WIP]};
            default: rd_word = 10'h000;
        endcase
        out16 = {rd_word[7:0], 6'h00, rd_word[9:8]};
        nxt_so = so_ff;
        // bit k of the data phase goes out after rising edge 16 + k
        if (HOLD_N_I && rd_active_ff && cnt_ff[4]) begin
            nxt_so = out16[~cnt_ff[3:0]];
        end
    end

    // output bit changes on the falling serial clock and clears when the select rises
    always_ff @(negedge SCK_I or posedge CS_N_I) begin
        if (CS_N_I) begin
            so_ff <= 1'b0;
        end else begin
            so_ff <= nxt_so;
        end
    end

    assign SO_O = so_ff;
    // pause floats the output too; enable drops with the select at once
    assign SO_OE_O = rd_active_ff & HOLD_N_I;

    ////////////////////////////////////////////////////////////////////////////////
    // pins and the done level into the system clock
    spwi_sync #(
        .W(4)
    ) u_sync (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .d_i({done_ff, DEV_ADDR_PIN_I, WP_N_I, CS_N_I}),
        .q_o(sync_q)
    );

    assign cs_s = sync_q[0];
    assign wp_s = sync_q[1];
    assign a0_s = sync_q[2];
    assign done_s = sync_q[3];

    // data register bank with its write timer
    spwi_nv_store #(
        .WIDTH(spwi_pkg::WIPER_W),
        .NUM(spwi_pkg::NUM_DR),
        .WRITE_CYCLES(NV_WRITE_CYCLES),
        .INIT(DR_INIT)
    ) u_nv (
        .clk_i(CLK_I),
        .resetn_i(RESETN_I),
        .start_i(nv_start),
        .idx_i(sel_ff),
        .data_i(nv_data),
        .busy_o(nv_busy),
        .bank_o(bank)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // command execution and wiper next state
    always_comb begin
        cmd_data = {dhi_ff, dlo_ff};
        nxt_cs_prev = cs_s;
        nxt_armed = armed_ff | (cs_prev_ff & ~cs_s);
        nxt_done_prev = done_s;
        // fields are steady: they changed at the latest on the serial edge that raised done
        exec = armed_ff & done_s & ~done_prev_ff;
        nxt_recall = 1'b0;
        nxt_wcr = wcr_ff;
        if (recall_ff) begin
            nxt_wcr = spwi_pkg::pick_dr(bank, 2'h0);
        end else if (exec && op_ff == spwi_pkg::OP_WR_WCR) begin
            nxt_wcr = cmd_data;
        end else if (exec && op_ff == spwi_pkg::OP_XFR_DR_TO_WCR) begin
            nxt_wcr = spwi_pkg::pick_dr(bank, sel_ff);
        end
        // data register writes while busy or protected are silently dropped
        nv_start = exec & wp_s & ~nv_busy &
                   (op_ff == spwi_pkg::OP_WR_DR || op_ff == spwi_pkg::OP_XFR_WCR_TO_DR);
        nv_data = (op_ff == spwi_pkg::OP_WR_DR) ? cmd_data : wcr_ff;
        nxt_tap = {{(spwi_pkg::TAP_COUNT-1){1'b0}}, 1'b1} << wcr_ff;
        // a running write keeps the part awake after deselect
        nxt_standby = cs_s & ~nv_busy;
        nxt_snap = snap_ff;
        if (cs_s) begin
            nxt_snap = {a0_s, nv_busy, wcr_ff, bank};
        end
    end

    // register the system side state
    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            cs_prev_ff <= 1'b0;
            armed_ff <= 1'b0;
            done_prev_ff <= 1'b0;
            recall_ff <= 1'b1;
            wcr_ff <= spwi_pkg::WIPER_RST;
            tap_ff <= '0;
            standby_ff <= 1'b0;
            snap_ff <= '0;
        end else begin
            cs_prev_ff <= nxt_cs_prev;
            armed_ff <= nxt_armed;
            done_prev_ff <= nxt_done_prev;
            recall_ff <= nxt_recall;
            wcr_ff <= nxt_wcr;
            tap_ff <= nxt_tap;
            standby_ff <= nxt_standby;
            snap_ff <= nxt_snap;
        end
    end

    assign WIPER_POS_O = wcr_ff;
    assign TAP_SEL_O = tap_ff;
    assign NV_BUSY_O = nv_busy;
    assign STANDBY_O = standby_ff;

endmodule

// >>> tb_top.sv
`timescale 1ns/10ps
// bench: host model on the serial pins, checks on the top-level outputs
module tb_top;
    localparam logic [3:0] DEVT = 4'h6; // arbitrary device type code
    localparam int NVC = 20; // short write cycle keeps the run brief
    localparam logic [9:0] DRI = 10'h2a5; // power-up register contents
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic wp_n = 1'b1;
    logic adr = 1'b1; // address pin level
    logic sck, cs_n, si, hold_n, so, so_oe, busy, stby;
    logic [9:0] wpos;
    logic [1023:0] tap;
    logic [15:0] rd;
    int fails = 0;
    int checked = 0;
    ////////////////////////////////////////////////////////////////////////
    always #25 clk = ~clk;
    spwi_host u_host (.sck_o(sck), .cs_n_o(cs_n), .si_o(si), .hold_n_o(hold_n), .so_i(so),
        .so_oe_i(so_oe));
    spwi_top #(.DEV_TYPE(DEVT), .NV_WRITE_CYCLES(NVC), .DR_INIT(DRI)) dut (
        .CLK_I(clk), .RESETN_I(resetn), .SCK_I(sck), .CS_N_I(cs_n), .SI_I(si),
        .HOLD_N_I(hold_n), .WP_N_I(wp_n), .DEV_ADDR_PIN_I(adr), .SO_O(so), .SO_OE_O(so_oe),
        .WIPER_POS_O(wpos), .TAP_SEL_O(tap), .NV_BUSY_O(busy), .STANDBY_O(stby));
    task automatic final_report();
        if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // word on the wire: low byte, then the two top bits
    function automatic logic [15:0] pk(input logic [9:0] d);
        return {d[7:0], 6'h00, d[9:8]};
    endfunction
    // identity, instruction and data; read direction for the read opcodes
    task automatic cmd(input logic [3:0] ty, input logic a, input logic [2:0] op,
                       input logic [1:0] sel, input logic [9:0] d, input int nb, input int pz);
        u_host.frame({ty, 2'b00, a, (op inside {3'h1, 3'h4, 3'h6}), op, 1'b0, sel, 2'b00,
            pk(d)}, nb, pz, rd);
    endtask
    task automatic chk_w(input logic [9:0] e);
        @(negedge clk);
        chk({6'h00, wpos}, {6'h00, e});
        chk({15'h0000, tap === (1024'h1 << e)}, 16'h0001);
    endtask
    // bounded wait for the write cycle to end
    task automatic nv_wait();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (n == 200) begin
            fails++;
            final_report();
        end
    endtask
    function automatic logic [9:0] dv(input int s);
        return 10'h0c3 ^ 10'(s * 'h111);
    endfunction
    initial begin
        fork
            begin
                repeat (2) @(negedge clk);
                resetn = 1'b1;
            end
            begin
                @(negedge clk);
                // begun under reset, so no select fall is seen and the write is dropped;
                // the snapshot is still empty, hence address bit zero
                cmd(DEVT, 1'b0, 3'h5, 2'h0, 10'h0aa, 32, -1);
            end
        join
        @(negedge clk);
        chk_w(DRI);
        repeat (3) @(negedge clk);
        chk({15'h0000, stby}, 16'h0001);
        cmd(DEVT, 1'b1, 3'h5, 2'h0, 10'h3ff, 32, -1);
        chk_w(10'h3ff);
        cmd(DEVT, 1'b1, 3'h4, 2'h0, 10'h000, 32, -1);
        chk(rd, pk(10'h3ff));
        cmd(DEVT, 1'b1, 3'h5, 2'h0, 10'h155, 32, 13);
        chk_w(10'h155);
        cmd(DEVT, 1'b1, 3'h4, 2'h0, 10'h000, 32, 20);
        chk(rd, pk(10'h155));
        cmd(DEVT, 1'b0, 3'h5, 2'h0, 10'h0aa, 32, -1);
        chk_w(10'h155);
        @(negedge clk) adr = 1'b0;
        repeat (4) @(negedge clk);
        cmd(DEVT, 1'b0, 3'h4, 2'h0, 10'h000, 32, -1);
        chk(rd, pk(10'h155));
        cmd(DEVT, 1'b1, 3'h4, 2'h0, 10'h000, 32, -1);
        chk(rd, 16'hxxxx);
        @(negedge clk) adr = 1'b1;
        repeat (4) @(negedge clk);
        cmd(~DEVT, 1'b1, 3'h5, 2'h0, 10'h0aa, 32, -1);
        chk_w(10'h155);
        cmd(DEVT, 1'b1, 3'h5, 2'h0, 10'h2aa, 20, -1);
        chk_w(10'h155);
        cmd(DEVT, 1'b1, 3'h5, 2'h0, 10'h2aa, 32, -1);
        chk_w(10'h2aa);
        for (int s = 0; s < 4; s++) begin
            cmd(DEVT, 1'b1, 3'h7, 2'(s), dv(s), 32, -1);
            chk({15'h0000, stby}, 16'h0000);
            cmd(DEVT, 1'b1, 3'h1, 2'h0, 10'h000, 32, -1);
            chk(rd, pk(10'h001));
            nv_wait();
        end
        cmd(DEVT, 1'b1, 3'h1, 2'h0, 10'h000, 32, -1);
        chk(rd, pk(10'h000));
        @(negedge clk) wp_n = 1'b0;
        cmd(DEVT, 1'b1, 3'h7, 2'h1, 10'h3ff, 32, -1);
        chk({15'h0000, busy}, 16'h0000);
        @(negedge clk) wp_n = 1'b1;
        cmd(DEVT, 1'b1, 3'h5, 2'h0, 10'h07e, 32, -1);
        cmd(DEVT, 1'b1, 3'h2, 2'h2, 10'h000, 16, -1);
        nv_wait();
        cmd(DEVT, 1'b1, 3'h5, 2'h0, 10'h000, 32, -1);
        cmd(DEVT, 1'b1, 3'h3, 2'h2, 10'h000, 16, -1);
        chk_w(10'h07e);
        for (int s = 0; s < 4; s++) begin
            cmd(DEVT, 1'b1, 3'h6, 2'(s), 10'h000, 32, -1);
            chk(rd, pk(s == 2 ? 10'h07e : dv(s)));
        end
        chk({15'h0000, stby}, 16'h0001);
        final_report();
    end
endmodule
